// ### i2c_evt_params.svh
// Constants for the I2C master event block: timing, bit slots, levels, flag positions.
// Assumes inclusion by bare name from every file that needs one of them.
`ifndef I2C_EVT_PARAMS_SVH
`define I2C_EVT_PARAMS_SVH

// ************************************************
// Timing
// ************************************************
`define SCL_PERIOD_NS 10000
`define LINK_CLK_NS 32
// Quarter SCL period in link clocks, rounded down so SCL never runs slow of spec
`define QTR_CYCLES ((`SCL_PERIOD_NS / 4) / `LINK_CLK_NS)
`define QTR_MIN 8
`define QTR_MAX 65535

// ************************************************
// Bit slots and bus levels
// ************************************************
`define ACK_BIT 4'h8
`define LAST_DATA_BIT 4'h7
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
`define ACK_LEVEL 1'b0
`define NACK_LEVEL 1'b1
`define LEN_W 8

// ************************************************
// Reset values and event flag positions
// ************************************************
`define PIN_REL_RST 1'b1
`define BUS_IDLE_LVL 1'b1
`define PIN_DRV_LVL 1'b0
`define FLAG_START 0
`define FLAG_STOP 1
`define FLAG_AL 2
`define FLAG_NACK 3

`endif

// ### i2c_evt_pkg.sv
// Types shared by the host port, the link engine and their carrier interface.
// Assumes nothing of its surroundings.
package i2c_evt_pkg;

  // ************************************************
  // Events passed from the link domain to the host domain
  // ************************************************
  typedef enum logic [2:0] {
    EVC_START = 3'b000,
    EVC_STOP = 3'b001,
    EVC_TX_END = 3'b010,
    EVC_RX_ADDR = 3'b011,
    EVC_RX_DATA = 3'b100,
    EVC_AL = 3'b101,
    EVC_NACK = 3'b110
  } evt_code_type;

  // ************************************************
  // Link engine states
  // ************************************************
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_START = 3'b001,
    ENG_SLOT = 3'b010,
    ENG_WAIT_DATA = 3'b011,
    ENG_STOP = 3'b100
  } eng_state_type;

endpackage

// ### i2c_link_if.sv
// Carrier between the host port (core clock) and the link engine (link clock).
// Every group is qualified by a toggle; command and data words hold still until the far side answers, event words get no answer.
`timescale 1ns/10ps
interface i2c_link_if
  import i2c_evt_pkg::*;
#(
  parameter int LEN_W = 8
);
  logic cmd_tgl;
  logic [6:0] cmd_addr;
  logic cmd_no_addr;
  logic [LEN_W-1:0] cmd_wr_len;
  logic [LEN_W-1:0] cmd_rd_len;
  logic data_tgl;
  logic [7:0] data_byte;
  logic taken_tgl;
  logic evt_tgl;
  evt_code_type evt_code;
  logic [7:0] evt_byte;

  modport host_side (
    output cmd_tgl, cmd_addr, cmd_no_addr, cmd_wr_len, cmd_rd_len, data_tgl, data_byte,
    input taken_tgl, evt_tgl, evt_code, evt_byte
  );

  modport link_side (
    input cmd_tgl, cmd_addr, cmd_no_addr, cmd_wr_len, cmd_rd_len, data_tgl, data_byte,
    output taken_tgl, evt_tgl, evt_code, evt_byte
  );
endinterface

// ### i2c_host_port.sv
// Host-facing side of the I2C master: transfer requests, transmit bytes, event outputs.
// Assumes the link engine keeps each event word still until its toggle is seen here.
`timescale 1ns/10ps
`include "i2c_evt_params.svh"
module i2c_host_port
  import i2c_evt_pkg::*;
#(
  parameter int LEN_W = `LEN_W
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic xfer_start,
  input wire logic [6:0] xfer_addr,
  input wire logic xfer_no_addr,
  input wire logic [LEN_W-1:0] xfer_wr_len,
  input wire logic [LEN_W-1:0] xfer_rd_len,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic busy,
  output logic event_error_irq,
  output logic start_flag,
  output logic stop_flag,
  output logic arbitration_lost_flag,
  output logic nack_flag,
  output logic transmit_end_irq,
  output logic receive_full_irq,
  i2c_link_if.host_side lnk
);

  typedef struct packed {
    logic cmd_tgl;
    logic [6:0] addr;
    logic no_addr;
    logic [LEN_W-1:0] wr_len;
    logic [LEN_W-1:0] rd_len;
    logic data_tgl;
    logic [7:0] data_byte;
    logic evt_s1;
    logic evt_s2;
    logic evt_seen;
    logic tk_s1;
    logic tk_s2;
    logic busy;
    logic tx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic eei;
    logic tei;
    logic rfi;
    logic [3:0] flags;
  } host_type;

  host_type host_reg;
  host_type host_next;

  // ************************************************
  // Next state
  // ************************************************
  always_comb
  begin
    host_next = host_reg;
    host_next.eei = 1'b0;
    host_next.tei = 1'b0;
    host_next.rfi = 1'b0;
    host_next.rx_valid = 1'b0;
    host_next.evt_s1 = lnk.evt_tgl;
    host_next.evt_s2 = host_reg.evt_s1;
    host_next.tk_s1 = lnk.taken_tgl;
    host_next.tk_s2 = host_reg.tk_s1;
    if (xfer_start && !host_reg.busy)
    begin
      host_next.cmd_tgl = ~host_reg.cmd_tgl;
      host_next.addr = xfer_addr;
      host_next.no_addr = xfer_no_addr;
      host_next.wr_len = xfer_wr_len;
      host_next.rd_len = xfer_rd_len;
      host_next.busy = 1'b1;
    end
    // One byte slot only; the next byte waits until the engine has taken this one
    if (tx_valid && host_reg.tx_ready)
    begin
      host_next.data_tgl = ~host_reg.data_tgl;
      host_next.data_byte = tx_data;
    end
    if (host_reg.evt_s2 != host_reg.evt_seen)
    begin
      host_next.evt_seen = host_reg.evt_s2;
      case (lnk.evt_code)
        EVC_START:
        begin
          host_next.eei = 1'b1;
          host_next.flags = 4'h1 << `FLAG_START;
        end
        EVC_STOP:
        begin
          host_next.eei = 1'b1;
          host_next.flags = 4'h1 << `FLAG_STOP;
          host_next.busy = 1'b0;
        end
        EVC_AL:
        begin
          host_next.eei = 1'b1;
          host_next.flags = 4'h1 << `FLAG_AL;
          host_next.busy = 1'b0;
        end
        EVC_NACK:
        begin
          host_next.eei = 1'b1;
          host_next.flags = 4'h1 << `FLAG_NACK;
        end
        EVC_TX_END: host_next.tei = 1'b1;
        EVC_RX_ADDR: host_next.rfi = 1'b1;
        EVC_RX_DATA:
        begin
          host_next.rfi = 1'b1;
          host_next.rx_valid = 1'b1;
          host_next.rx_data = lnk.evt_byte;
        end
        default: host_next.eei = 1'b0;
      endcase
    end
    host_next.tx_ready = host_next.busy && (host_next.data_tgl == host_next.tk_s2);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      host_reg <= '0;
    else
      host_reg <= host_next;
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign lnk.cmd_tgl = host_reg.cmd_tgl;
  assign lnk.cmd_addr = host_reg.addr;
  assign lnk.cmd_no_addr = host_reg.no_addr;
  assign lnk.cmd_wr_len = host_reg.wr_len;
  assign lnk.cmd_rd_len = host_reg.rd_len;
  assign lnk.data_tgl = host_reg.data_tgl;
  assign lnk.data_byte = host_reg.data_byte;
  assign tx_ready = host_reg.tx_ready;
  assign rx_data = host_reg.rx_data;
  assign rx_valid = host_reg.rx_valid;
  assign busy = host_reg.busy;
  assign event_error_irq = host_reg.eei;
  assign start_flag = host_reg.flags[`FLAG_START];
  assign stop_flag = host_reg.flags[`FLAG_STOP];
  assign arbitration_lost_flag = host_reg.flags[`FLAG_AL];
  assign nack_flag = host_reg.flags[`FLAG_NACK];
  assign transmit_end_irq = host_reg.tei;
  assign receive_full_irq = host_reg.rfi;

endmodule

// ### i2c_master_irq_timing.sv
// Single-master I2C engine with transfer event reporting; top of the block.
// Assumes open-drain SCL/SDA pads outside and a free-running link_clk.
`timescale 1ns/10ps
`include "i2c_evt_params.svh"
module i2c_master_irq_timing
  import i2c_evt_pkg::*;
#(
  parameter int LEN_W = `LEN_W,
  parameter int QTR_CYCLES = `QTR_CYCLES
)(
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic xfer_start,
  input wire logic [6:0] xfer_addr,
  input wire logic xfer_no_addr,
  input wire logic [LEN_W-1:0] xfer_wr_len,
  input wire logic [LEN_W-1:0] xfer_rd_len,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic busy,
  output logic event_error_irq,
  output logic start_flag,
  output logic stop_flag,
  output logic arbitration_lost_flag,
  output logic nack_flag,
  output logic transmit_end_irq,
  output logic receive_full_irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);

  // ************************************************
  // Parameter check
  // ************************************************
  // Events must stay apart long enough for the host side to see each toggle
  generate
    if (QTR_CYCLES < `QTR_MIN || QTR_CYCLES > `QTR_MAX || LEN_W < 1)
    begin : g_bad_param
      $error("Unsupported QTR_CYCLES or LEN_W");
    end
  endgenerate

  i2c_link_if #(.LEN_W(LEN_W)) lnk ();

  i2c_host_port #(.LEN_W(LEN_W)) u_host (
    .core_clk(core_clk),
    .resetn(resetn),
    .xfer_start(xfer_start),
    .xfer_addr(xfer_addr),
    .xfer_no_addr(xfer_no_addr),
    .xfer_wr_len(xfer_wr_len),
    .xfer_rd_len(xfer_rd_len),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .busy(busy),
    .event_error_irq(event_error_irq),
    .start_flag(start_flag),
    .stop_flag(stop_flag),
    .arbitration_lost_flag(arbitration_lost_flag),
    .nack_flag(nack_flag),
    .transmit_end_irq(transmit_end_irq),
    .receive_full_irq(receive_full_irq),
    .lnk(lnk)
  );

  typedef struct packed {
    eng_state_type st;
    logic [15:0] q;
    logic [1:0] ph;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic is_addr;
    logic addr_rd;
    logic rd_mode;
    logic nack_seen;
    logic no_addr;
    logic [LEN_W-1:0] wr_left;
    logic [LEN_W-1:0] rd_left;
    logic [6:0] addr;
    logic cmd_s1;
    logic cmd_s2;
    logic cmd_seen;
    logic dat_s1;
    logic dat_s2;
    logic taken;
    logic evt_tgl;
    evt_code_type evt_code;
    logic [7:0] evt_byte;
    logic [2:0] scl_p;
    logic [2:0] sda_p;
    logic scl_f;
    logic sda_f;
    logic sda_fd;
    logic scl_rel;
    logic sda_rel;
    logic pin_lvl;
  } eng_type;

  localparam eng_type ENG_RST = '{
    st: ENG_IDLE,
    evt_code: EVC_START,
    scl_p: {3{`BUS_IDLE_LVL}},
    sda_p: {3{`BUS_IDLE_LVL}},
    scl_f: `BUS_IDLE_LVL,
    sda_f: `BUS_IDLE_LVL,
    sda_fd: `BUS_IDLE_LVL,
    scl_rel: `PIN_REL_RST,
    sda_rel: `PIN_REL_RST,
    pin_lvl: `PIN_DRV_LVL,
    default: '0
  };

  localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);

  eng_type eng_reg;
  eng_type eng_next;
  logic tick;
  logic sample;
  logic rd_dir;
  logic ev_fire;
  evt_code_type ev_code;
  logic [7:0] ev_byte;
  logic [LEN_W-1:0] wr_n;
  logic [LEN_W-1:0] rd_n;

  // ************************************************
  // Link engine
  // ************************************************
  always_comb
  begin
    eng_next = eng_reg;
    ev_fire = 1'b0;
    ev_code = EVC_START;
    ev_byte = eng_reg.shreg;
    sample = eng_reg.sda_f;
    tick = (eng_reg.q == 16'(QTR_CYCLES - 1));
    rd_dir = (eng_reg.wr_left == '0) && (eng_reg.rd_left != '0);
    wr_n = (eng_reg.is_addr || eng_reg.rd_mode) ? eng_reg.wr_left : eng_reg.wr_left - LEN_ONE;
    rd_n = eng_reg.rd_mode ? eng_reg.rd_left - LEN_ONE : eng_reg.rd_left;
    eng_next.q = tick ? 16'h0000 : eng_reg.q + 16'h0001;
    eng_next.cmd_s1 = lnk.cmd_tgl;
    eng_next.cmd_s2 = eng_reg.cmd_s1;
    eng_next.dat_s1 = lnk.data_tgl;
    eng_next.dat_s2 = eng_reg.dat_s1;
    // Pins settle only when the second and third stages agree
    eng_next.scl_p = {eng_reg.scl_p[1:0], scl_in};
    eng_next.sda_p = {eng_reg.sda_p[1:0], sda_in};
    if (eng_reg.scl_p[2] == eng_reg.scl_p[1])
      eng_next.scl_f = eng_reg.scl_p[2];
    if (eng_reg.sda_p[2] == eng_reg.sda_p[1])
      eng_next.sda_f = eng_reg.sda_p[2];
    eng_next.sda_fd = eng_reg.sda_f;
    case (eng_reg.st)
      ENG_IDLE:
      begin
        eng_next.q = 16'h0000;
        eng_next.ph = 2'b00;
        eng_next.scl_rel = 1'b1;
        eng_next.sda_rel = 1'b1;
        if (eng_reg.cmd_s2 != eng_reg.cmd_seen)
        begin
          eng_next.cmd_seen = eng_reg.cmd_s2;
          eng_next.addr = lnk.cmd_addr;
          eng_next.no_addr = lnk.cmd_no_addr;
          eng_next.wr_left = lnk.cmd_wr_len;
          eng_next.rd_left = lnk.cmd_rd_len;
          eng_next.nack_seen = 1'b0;
          eng_next.st = ENG_START;
        end
        else
          eng_next.taken = eng_reg.dat_s2; // Stale bytes from an aborted write are dropped
      end
      ENG_START:
      if (tick)
      begin
        eng_next.ph = eng_reg.ph + 2'b01;
        case (eng_reg.ph)
          2'b00: eng_next.sda_rel = 1'b1;
          2'b01: eng_next.scl_rel = 1'b1;
          2'b10: eng_next.sda_rel = 1'b0;
          default:
          begin
            eng_next.scl_rel = 1'b0;
            eng_next.bit_cnt = 4'h0;
            if (eng_reg.no_addr)
              eng_next.st = ENG_STOP;
            else
            begin
              eng_next.st = ENG_SLOT;
              eng_next.is_addr = 1'b1;
              eng_next.rd_mode = 1'b0;
              eng_next.addr_rd = rd_dir;
              eng_next.shreg = {eng_reg.addr, rd_dir ? `DIR_READ : `DIR_WRITE};
            end
          end
        endcase
      end
      ENG_SLOT:
      if (tick)
      begin
        eng_next.ph = eng_reg.ph + 2'b01;
        case (eng_reg.ph)
          2'b00:
          if (eng_reg.bit_cnt == `ACK_BIT)
            eng_next.sda_rel = !eng_reg.rd_mode ? 1'b1 :
              ((eng_reg.rd_left == LEN_ONE) ? `NACK_LEVEL : `ACK_LEVEL);
          else
            eng_next.sda_rel = eng_reg.rd_mode ? 1'b1 : eng_reg.shreg[7];
          2'b01: eng_next.scl_rel = 1'b1;
          2'b10:
          if (eng_reg.bit_cnt != `ACK_BIT)
          begin
            eng_next.shreg = {eng_reg.shreg[6:0], eng_reg.rd_mode ? sample : 1'b0};
            if (!eng_reg.rd_mode && eng_reg.sda_rel && !sample)
            begin
              ev_fire = 1'b1;
              ev_code = EVC_AL;
              eng_next.st = ENG_IDLE;
            end
            else if (eng_reg.rd_mode && eng_reg.bit_cnt == `LAST_DATA_BIT &&
                     eng_reg.rd_left == LEN_ONE)
            begin
              ev_fire = 1'b1;
              ev_code = EVC_RX_DATA;
              ev_byte = {eng_reg.shreg[6:0], sample};
            end
          end
          else if (!eng_reg.rd_mode)
          begin
            ev_fire = 1'b1;
            if (sample == `NACK_LEVEL)
            begin
              ev_code = EVC_NACK;
              eng_next.nack_seen = 1'b1;
            end
            else if (eng_reg.is_addr && eng_reg.addr_rd)
              ev_code = EVC_RX_ADDR;
            else
              ev_code = EVC_TX_END;
          end
          else if (eng_reg.rd_left != LEN_ONE)
          begin
            ev_fire = 1'b1;
            ev_code = EVC_RX_DATA;
          end
          default:
          begin
            eng_next.scl_rel = 1'b0;
            eng_next.bit_cnt = eng_reg.bit_cnt + 4'h1;
            if (eng_reg.bit_cnt == `ACK_BIT)
            begin
              eng_next.bit_cnt = 4'h0;
              eng_next.wr_left = wr_n;
              eng_next.rd_left = rd_n;
              eng_next.is_addr = 1'b0;
              if (eng_reg.nack_seen)
                eng_next.st = ENG_STOP;
              else if (eng_reg.is_addr && eng_reg.addr_rd)
                eng_next.rd_mode = 1'b1;
              else if (eng_reg.rd_mode)
              begin
                if (rd_n == '0)
                  eng_next.st = ENG_STOP;
              end
              else if (wr_n != '0)
                eng_next.st = ENG_WAIT_DATA;
              else if (rd_n != '0)
                eng_next.st = ENG_START;
              else
                eng_next.st = ENG_STOP;
            end
          end
        endcase
      end
      ENG_WAIT_DATA:
      begin
        // SCL stays low here, so a slow host stretches the bus instead of losing data
        eng_next.q = 16'h0000;
        eng_next.ph = 2'b00;
        if (eng_reg.dat_s2 != eng_reg.taken)
        begin
          eng_next.taken = eng_reg.dat_s2;
          eng_next.shreg = lnk.data_byte;
          eng_next.st = ENG_SLOT;
        end
      end
      ENG_STOP:
      if (tick)
      begin
        eng_next.ph = eng_reg.ph + 2'b01;
        case (eng_reg.ph)
          2'b00: eng_next.sda_rel = 1'b0;
          2'b01: eng_next.scl_rel = 1'b1;
          2'b10: eng_next.sda_rel = 1'b1;
          default: eng_next.st = ENG_IDLE;
        endcase
      end
      default: eng_next.st = ENG_IDLE;
    endcase
    // Conditions are taken from the bus itself, so any start or stop is reported
    if (eng_reg.scl_f && eng_reg.sda_fd && !eng_reg.sda_f)
    begin
      ev_fire = 1'b1;
      ev_code = EVC_START;
    end
    else if (eng_reg.scl_f && !eng_reg.sda_fd && eng_reg.sda_f)
    begin
      ev_fire = 1'b1;
      ev_code = EVC_STOP;
    end
    if (ev_fire)
    begin
      eng_next.evt_tgl = ~eng_reg.evt_tgl;
      eng_next.evt_code = ev_code;
      eng_next.evt_byte = ev_byte;
    end
  end

  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
      eng_reg <= ENG_RST;
    else
      eng_reg <= eng_next;
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign lnk.taken_tgl = eng_reg.taken;
  assign lnk.evt_tgl = eng_reg.evt_tgl;
  assign lnk.evt_code = eng_reg.evt_code;
  assign lnk.evt_byte = eng_reg.evt_byte;
  assign scl_out = eng_reg.pin_lvl;
  assign sda_out = eng_reg.pin_lvl;
  assign scl_oe_n = eng_reg.scl_rel;
  assign sda_oe_n = eng_reg.sda_rel;

endmodule

// ### i2c_irq_asserts.sv
// Concurrent checks on the I2C event block top ports.
// Assumes a single core clock domain and the active-low reset.
`timescale 1ns/10ps
module i2c_irq_asserts (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic busy,
  input wire logic event_error_irq,
  input wire logic start_flag,
  input wire logic stop_flag,
  input wire logic arbitration_lost_flag,
  input wire logic nack_flag,
  input wire logic transmit_end_irq,
  input wire logic receive_full_irq,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  // ************************************************
  // Properties
  // ************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_start;
    event_error_irq && start_flag;
  endsequence
  sequence s_stop;
    event_error_irq && stop_flag;
  endsequence
  AST_START_FIRST: assert property ($rose(busy) |-> ##[1:100] s_start)
    else $error("no start event after request");
  AST_FLAG_ONEHOT: assert property (event_error_irq |->
    $onehot({start_flag, stop_flag, arbitration_lost_flag, nack_flag}))
    else $error("event flags not one-hot");
  AST_FLAG_HOLD: assert property (!event_error_irq |->
    $stable({start_flag, stop_flag, arbitration_lost_flag, nack_flag}))
    else $error("flags moved without event");
  AST_EVT_PULSE: assert property (event_error_irq |=> !event_error_irq)
    else $error("event pulse too long");
  AST_STOP_IDLE: assert property (s_stop |-> ##[0:2] !busy)
    else $error("busy after stop");
  AST_NACK_STOP: assert property (event_error_irq && nack_flag |-> ##[1:200] s_stop)
    else $error("no stop after nack");
  AST_IRQ_EXCL: assert property
    ($onehot0({event_error_irq, transmit_end_irq, receive_full_irq}))
    else $error("two events at once");
  AST_RX_IRQ: assert property (rx_valid |-> receive_full_irq)
    else $error("byte without receive irq");
  AST_TX_TAKE: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("slot not closed");
  AST_IDLE_REL: assert property (!busy |-> scl_oe_n && sda_oe_n)
    else $error("bus held while idle");
endmodule

bind i2c_master_irq_timing i2c_irq_asserts u_chk (.core_clk, .resetn, .busy,
  .event_error_irq, .start_flag, .stop_flag, .arbitration_lost_flag, .nack_flag,
  .transmit_end_irq, .receive_full_irq, .rx_valid, .tx_valid, .tx_ready, .scl_oe_n,
  .sda_oe_n);

// ### i2c_slave_model.sv
// Behavioural I2C slave: acks its address, logs writes, serves read bytes.
// Assumes pulled-up wires; no clock stretching, as the master cannot take it.
`timescale 1ns/10ps
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
)(
  input wire logic scl,
  input wire logic sda,
  output logic sda_low
);
  // ************************************************
  // Bit engine
  // ************************************************
  logic [7:0] sh, cur, mkl;
  logic [15:0] adl;
  logic [31:0] wrl;
  logic [7:0] tx_q[$];
  logic act, first, rd, ok;
  int bitn;
  initial
  begin
    sda_low = 1'b0;
    act = 1'b0;
    ok = 1'b0;
  end
  always @(negedge sda)
    if (scl)
    begin
      act = 1'b1;
      first = 1'b1;
      bitn = 0;
      ok = 1'b0;
    end
  always @(posedge sda)
    if (scl)
      act = 1'b0;
  always @(posedge scl)
    if (act)
    begin
      if (bitn < 8)
        sh = {sh[6:0], sda};
      if (first && bitn == 7)
      begin
        rd = sda;
        ok = (sh[7:1] == ADDR);
      end
      if (bitn == 8)
      begin
        if (first)
          adl = {adl[7:0], sh};
        else if (rd)
        begin
          mkl = {mkl[6:0], sda};
          ok = ok && !sda;
        end
        else
          wrl = {wrl[23:0], sh};
        first = 1'b0;
        bitn = 0;
      end
      else
        bitn++;
    end
  // Release on every falling SCL so a stop is never blocked
  always @(negedge scl)
  begin
    sda_low = 1'b0;
    if (act && ok)
    begin
      if (bitn == 8 && (first || !rd))
        sda_low = 1'b1;
      if (rd && !first && bitn < 8)
      begin
        if (bitn == 0)
          cur = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hFF;
        sda_low = !cur[7 - bitn];
      end
    end
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the I2C event block with a slave model.
// Assumes the design package and the slave model are compiled first.
`timescale 1ns/10ps
module tb_top;
  // ************************************************
  // Harness
  // ************************************************
  localparam logic [6:0] SA = 7'h2A;
  logic core_clk, link_clk, resetn, xfer_start, xfer_no_addr, tx_valid, al_low, slv_low;
  logic [6:0] xfer_addr;
  logic [7:0] xfer_wr_len, xfer_rd_len, tx_data, rx_data, sc;
  logic tx_ready, rx_valid, busy, event_error_irq, start_flag, stop_flag;
  logic arbitration_lost_flag, nack_flag, transmit_end_irq, receive_full_irq;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic [63:0] evl, rxl, rcl;
  logic [7:0] txb[$];
  int n_mismatch, check_count;
  wire scl_w = scl_oe_n;
  wire sda_w = sda_oe_n && !slv_low && !al_low;
  i2c_master_irq_timing #(.QTR_CYCLES(8)) dut (.core_clk, .link_clk, .resetn, .xfer_start,
    .xfer_addr, .xfer_no_addr, .xfer_wr_len, .xfer_rd_len, .tx_data, .tx_valid, .tx_ready,
    .rx_data, .rx_valid, .busy, .event_error_irq, .start_flag, .stop_flag,
    .arbitration_lost_flag, .nack_flag, .transmit_end_irq, .receive_full_irq,
    .scl_in(scl_w), .scl_out, .scl_oe_n, .sda_in(sda_w), .sda_out, .sda_oe_n);
  i2c_slave_model #(.ADDR(SA)) slv (.scl(scl_w), .sda(sda_w), .sda_low(slv_low));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // Event log in nibbles: 1 start, 2 stop, 3 lost, 4 nack, 5 tx end, 6 rx full
  always @(posedge core_clk)
  begin
    if (event_error_irq)
      evl <= {evl[59:0], start_flag ? 4'h1 : stop_flag ? 4'h2 :
        arbitration_lost_flag ? 4'h3 : 4'h4};
    if (transmit_end_irq || receive_full_irq)
    begin
      evl <= {evl[59:0], transmit_end_irq ? 4'h5 : 4'h6};
      rcl <= {rcl[55:0], sc};
    end
    if (rx_valid)
      rxl <= {rxl[55:0], rx_data};
  end
  // SCL rises counted from each start, so irq timing shows the bit slot
  always @(posedge scl_w)
    sc = sc + 8'h01;
  always @(negedge sda_w)
    if (scl_w)
      sc = 8'h00;
  // ************************************************
  // Tasks
  // ************************************************
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input logic [6:0] a, input logic na, input logic [7:0] wr,
    input logic [7:0] rd);
    evl = 64'h0;
    rxl = 64'h0;
    rcl = 64'h0;
    @(posedge core_clk);
    xfer_addr <= a;
    xfer_no_addr <= na;
    xfer_wr_len <= wr;
    xfer_rd_len <= rd;
    xfer_start <= 1'b1;
    @(posedge core_clk);
    xfer_start <= 1'b0;
    foreach (txb[k])
    begin
      tx_data <= txb[k];
      tx_valid <= 1'b1;
      repeat (5000)
      begin
        @(posedge core_clk);
        if (tx_ready === 1'b1)
          break;
      end
      chk("byte taken", 64'(tx_ready), 64'h1);
    end
    tx_valid <= 1'b0;
    repeat (20000)
    begin
      @(posedge core_clk);
      if (busy === 1'b0)
        break;
    end
    chk("busy end", 64'(busy), 64'h0);
    repeat (40) @(posedge core_clk);
    txb.delete();
  endtask
  task automatic t_write;
    txb = '{8'hA5, 8'h3C};
    run(SA, 1'b0, 8'h02, 8'h00);
    chk("write events", evl, 64'h15552);
    chk("write slots", rcl, 64'h09121B);
    chk("bytes at slave", 64'(slv.wrl[15:0]), 64'hA53C);
    chk("write address", 64'(slv.adl[7:0]), 64'h54);
    $display("test write done");
  endtask
  task automatic t_addr_only;
    run(SA, 1'b0, 8'h00, 8'h00);
    chk("address only events", evl, 64'h152);
    $display("test address only done");
  endtask
  task automatic t_no_addr;
    run(SA, 1'b1, 8'h00, 8'h00);
    chk("start stop events", evl, 64'h12);
    chk("stop flag", 64'(stop_flag), 64'h1);
    chk("pin levels", 64'({scl_out, sda_out}), 64'h0);
    $display("test start stop done");
  endtask
  task automatic t_read;
    slv.tx_q.push_back(8'h81);
    slv.tx_q.push_back(8'h7E);
    run(SA, 1'b0, 8'h00, 8'h02);
    chk("read events", evl, 64'h16662);
    chk("read slots", rcl, 64'h09121A);
    chk("read bytes", rxl, 64'h817E);
    chk("master acks", 64'(slv.mkl[1:0]), 64'h1);
    $display("test read done");
  endtask
  task automatic t_comp;
    txb = '{8'hC3};
    slv.tx_q.push_back(8'h5A);
    slv.tx_q.push_back(8'h0F);
    run(SA, 1'b0, 8'h01, 8'h02);
    chk("composite events", evl, 64'h15516662);
    chk("composite slots", rcl, 64'h091209121A);
    chk("address bytes", 64'(slv.adl), 64'h5455);
    chk("composite bytes", rxl, 64'h5A0F);
    chk("composite write", 64'(slv.wrl[7:0]), 64'hC3);
    $display("test composite done");
  endtask
  task automatic t_nack;
    run(7'h11, 1'b0, 8'h00, 8'h00);
    chk("nack events", evl, 64'h142);
    $display("test nack done");
  endtask
  task automatic t_al;
    fork
      run(7'h7F, 1'b0, 8'h00, 8'h00);
      repeat (2000)
      begin
        @(posedge core_clk);
        if (event_error_irq === 1'b1)
          break;
      end
    join_any
    al_low <= 1'b1;
    wait fork;
    chk("lost events", evl, 64'h13);
    chk("lost flag", 64'(arbitration_lost_flag), 64'h1);
    al_low <= 1'b0;
    repeat (100) @(posedge core_clk);
    $display("test arbitration done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ************************************************
  // Sequence
  // ************************************************
  initial
  begin
    {resetn, xfer_start, xfer_no_addr, tx_valid, al_low} = 5'h0;
    {xfer_addr, xfer_wr_len, xfer_rd_len, tx_data, sc} = 39'h0;
    n_mismatch = 0;
    check_count = 0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_write;
    t_addr_only;
    t_no_addr;
    t_read;
    t_comp;
    t_nack;
    t_al;
    stop_test;
  end
  // Whole run is near 3100 cycles; the limit leaves ample margin
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    stop_test;
  end
endmodule
